// [emb_cfg.svh]
// emb_cfg.svh: constants for the external memory bus pin block.
// assumes: included by bare name from package and modules.
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
`define EMB_DATA_W 32
`define EMB_ADDR_W 22
`define EMB_BA_LSB 20
`define EMB_BA_MSB 21
`define EMB_ROWCOL_MSB 12
`define EMB_WIDTH_BYTE 2'h1
`define EMB_WIDTH_HALF 2'h2
`define EMB_WIDTH_WORD 2'h3
`define EMB_WIDTH_RSVD 2'h0
`define EMB_STATIC_RD_NS 120
`define EMB_CLK_NS 40
`define EMB_STATIC_RD_CYC ((`EMB_STATIC_RD_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)
`define EMB_SD_CAS_CYC 2
`define EMB_WAIT_CNT_W 4
`endif

// [emb_pkg.sv]
// emb_pkg.sv: types for the external memory bus pin block.
// assumes: emb_cfg.svh sits in the same folder.
`default_nettype none
`include "emb_cfg.svh"
package emb_pkg;
  // target of one access
  typedef enum logic [2:0] {
    EMB_TGT_SDRAM = 3'h1,
    EMB_TGT_STATIC = 3'h2,
    EMB_TGT_IO = 3'h4
  } emb_tgt_e;
  // request from the internal side
  typedef struct packed {
    emb_tgt_e tgt;
    logic [1:0] bank;
    logic write;
    logic [3:0] byte_en;
    logic [`EMB_ADDR_W-1:0] addr;
    logic [`EMB_DATA_W-1:0] wdata;
  } emb_req_s;
  // sdram command strobes, all active low
  typedef struct packed {
    logic [1:0] bank_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_n;
  } emb_sdcmd_s;
  // sequencer states
  typedef enum logic [4:0] {
    EMB_IDLE = 5'h01,
    EMB_SD_ROW = 5'h02,
    EMB_SD_COL = 5'h04,
    EMB_ST_ACC = 5'h08,
    EMB_DONE = 5'h10
  } emb_state_e;
endpackage
`default_nettype wire

// [emb_strap_latch.sv]
// emb_strap_latch.sv: catches a strap level while reset is held.
// assumes: strap driven by the board throughout reset.
`timescale 1ns/1ps
`default_nettype none
module emb_strap_latch #(
  parameter int W = 1
) (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic hold_i, // high while reset stands
  input wire logic [W-1:0] strap_i, // pin level
  output logic [W-1:0] value_o // captured strap
);
  logic [W-1:0] value_q;
  // sampled on clock edges while hold is high, then frozen
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      value_q <= '0;
    else if (hold_i)
      value_q <= strap_i;
  end
  assign value_o = value_q;
endmodule // emb_strap_latch
`default_nettype wire

// [emb_lane_ctl.sv]
// emb_lane_ctl.sv: per-lane byte enable and mask registers.
// assumes: one instance per data lane.
`timescale 1ns/1ps
`default_nettype none
module emb_lane_ctl (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic load_i, // new access starts
  input wire logic clear_i, // access ends
  input wire logic sdram_i, // access is to sdram
  input wire logic write_i, // write access
  input wire logic en_i, // lane is used
  output logic mask_o, // sdram byte mask, high masks
  output logic wr_n_o // static byte write, low writes
);
  logic mask_q;
  logic wr_n_q;
  // idle: mask high (sdram output off), write enables high
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mask_q <= 1'b1;
      wr_n_q <= 1'b1;
    end
    else if (load_i)
    begin
      mask_q <= sdram_i ? !en_i : 1'b1;
      wr_n_q <= !(!sdram_i && write_i && en_i);
    end
    else if (clear_i)
    begin
      mask_q <= 1'b1;
      wr_n_q <= 1'b1;
    end
  end
  assign mask_o = mask_q;
  assign wr_n_o = wr_n_q;
endmodule // emb_lane_ctl
`default_nettype wire

// [emb_mem_bus.sv]
// emb_mem_bus.sv: pin sequencer for sdram, static and i/o banks.
// assumes: one request at a time, held until done_o.
`timescale 1ns/1ps
`default_nettype none
`include "emb_cfg.svh"
module emb_mem_bus (
  input wire logic clock_i, // system clock, 25 MHz
  input wire logic arst_n_i, // async reset, active low
  input wire logic req_valid_i, // access request
  input wire emb_pkg::emb_req_s req_i, // request fields
  input wire logic static_swap_i, // swap static bank selects
  input wire logic [1:0] static1_width_i, // width of static bank 1
  output logic done_o, // one-cycle access done pulse
  output logic [`EMB_DATA_W-1:0] rdata_o, // read data
  output logic wdog_active_high_o, // captured watchdog polarity
  output logic [1:0] boot_width_o, // captured bank 0 width
  output logic boot_width_bad_o, // reserved width strapped
  output logic sys_clock_out_o, // system clock to sdram
  output logic [`EMB_ADDR_W-1:0] addr_o, // address pins
  input wire logic [`EMB_DATA_W-1:0] data_i, // data pins in
  output logic [`EMB_DATA_W-1:0] data_o, // data pins out
  output logic [3:0] data_oe_n_o, // lane output enables, low drives
  output logic [1:0] sdram_bank_select_n_o, // sdram chip selects
  output logic sdram_row_strobe_n_o, // sdram row strobe
  output logic sdram_col_strobe_n_o, // sdram column strobe
  output logic sdram_write_n_o, // sdram write enable
  output logic [3:0] sdram_byte_mask_o, // sdram byte masks
  output logic [3:0] static_byte_write_n_o, // static byte writes, low writes
  output logic [2:0] io_bank_select_n_o, // i/o bank selects
  output logic [1:0] static_bank_select_n_o, // static bank selects
  input wire logic static_output_enable_n_i, // oe pin level (strap)
  output logic static_output_enable_n_o, // oe pin drive
  output logic static_output_enable_oe_n_o, // oe pin enable, low drives
  input wire logic [1:0] boot_bank_width_strap_i, // width straps
  input wire logic ext_wait_n_i // external wait, active low
);
  import emb_pkg::*;

  // ----------------------------------------
  // straps, caught on the first clock edge after reset release
  // ----------------------------------------
  logic rst_hold_q;
  logic [1:0] width_q;
  logic pol_q;
  // reset-held flag goes low one edge after release
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_hold_q <= 1'b1;
    else
      rst_hold_q <= 1'b0;
  end
  emb_strap_latch #(.W(1)) u_pol (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .hold_i(rst_hold_q),
    .strap_i(static_output_enable_n_i),
    .value_o(pol_q)
  );
  emb_strap_latch #(.W(2)) u_width (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .hold_i(rst_hold_q),
    .strap_i(boot_bank_width_strap_i),
    .value_o(width_q)
  );
  assign wdog_active_high_o = pol_q;
  assign boot_width_o = width_q;
  assign boot_width_bad_o = (width_q == `EMB_WIDTH_RSVD);
  // oe pin stays released while straps are read, so the board level wins
  assign static_output_enable_oe_n_o = rst_hold_q;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  emb_state_e state_q;
  emb_state_e state_d;
  emb_req_s req_q;
  // pins launch on the taking edge, before req_q holds the request,
  // so while idle the decode looks at the live request
  wire emb_req_s req_v = (state_q == EMB_IDLE) ? req_i : req_q;
  wire is_sd = (req_v.tgt == EMB_TGT_SDRAM);
  wire is_io = (req_v.tgt == EMB_TGT_IO);
  wire is_st = (req_v.tgt == EMB_TGT_STATIC);
  // physical static bank after the programmable mapping
  wire phys_bank = req_v.bank[0] ^ static_swap_i;
  // bank 0 boots at the strap width; a reserved strap falls back to word
  wire [1:0] st_width = !phys_bank ? width_q : static1_width_i;
  wire [1:0] eff_width = (is_st && st_width != `EMB_WIDTH_RSVD) ? st_width
                         : `EMB_WIDTH_WORD;
  // byte address on a byte bus is presented whole; half bus drops bit 0, word bus bits 1:0
  wire [`EMB_ADDR_W-1:0] st_addr = (eff_width == `EMB_WIDTH_WORD)
    ? {req_v.addr[`EMB_ADDR_W-1:2], 2'h0}
    : (eff_width == `EMB_WIDTH_HALF) ? {req_v.addr[`EMB_ADDR_W-1:1], 1'h0}
    : req_v.addr;
  // sdram row and column fields sit on 12:0, bank on 21:20
  wire [`EMB_ROWCOL_MSB:0] sd_row = req_v.addr[`EMB_ROWCOL_MSB+2:2];
  wire [`EMB_ROWCOL_MSB:0] sd_col = {4'h0, req_v.addr[10:2]};
  wire [1:0] sd_ba = req_v.addr[`EMB_BA_MSB:`EMB_BA_LSB];
  wire [`EMB_ADDR_W-1:0] sd_row_pins = {sd_ba, 7'h00, sd_row};
  wire [`EMB_ADDR_W-1:0] sd_col_pins = {sd_ba, 7'h00, sd_col};
  // narrow-bus write data replicated so lane 0 carries the byte
  wire [`EMB_DATA_W-1:0] narrow_wdata = (eff_width == `EMB_WIDTH_BYTE)
    ? {4{req_v.wdata[8*req_v.addr[1:0] +: 8]}}
    : (eff_width == `EMB_WIDTH_HALF) ? {2{req_v.wdata[16*req_v.addr[1] +: 16]}}
    : req_v.wdata;
  wire [3:0] lane_en = (eff_width == `EMB_WIDTH_WORD) ? req_v.byte_en
    : (eff_width == `EMB_WIDTH_HALF) ? 4'h3 : 4'h1;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic [`EMB_WAIT_CNT_W-1:0] cnt_q;
  logic [`EMB_WAIT_CNT_W-1:0] cnt_d;
  wire cnt_zero = (cnt_q == '0);
  wire start = (state_q == EMB_IDLE) && req_valid_i && !rst_hold_q;
  wire wait_on = !ext_wait_n_i;
  // next state: sdram row then column, static holds until count and wait clear
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      EMB_IDLE:
        if (start)
        begin
          state_d = (req_i.tgt == EMB_TGT_SDRAM) ? EMB_SD_ROW : EMB_ST_ACC;
          cnt_d = (req_i.tgt == EMB_TGT_SDRAM)
            ? `EMB_WAIT_CNT_W'(`EMB_SD_CAS_CYC)
            : `EMB_WAIT_CNT_W'(`EMB_STATIC_RD_CYC);
        end
      EMB_SD_ROW:
        state_d = EMB_SD_COL;
      EMB_SD_COL:
        if (cnt_zero)
          state_d = EMB_DONE;
        else
          cnt_d = cnt_q - 1'b1;
      EMB_ST_ACC:
        if (!cnt_zero)
          cnt_d = cnt_q - 1'b1;
        else if (!wait_on)
          state_d = EMB_DONE;
      EMB_DONE:
        state_d = EMB_IDLE;
      default:
        state_d = EMB_IDLE;
    endcase
  end
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= EMB_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      req_q <= '0;
    else if (start)
      req_q <= req_i;
  end

  // ----------------------------------------
  // pin registers
  // ----------------------------------------
  wire in_st = (state_q == EMB_ST_ACC);
  wire going_st = (state_d == EMB_ST_ACC);
  wire going_row = (state_d == EMB_SD_ROW);
  wire going_col = (state_d == EMB_SD_COL) && (state_q == EMB_SD_ROW);
  emb_sdcmd_s sd_q;
  logic [`EMB_ADDR_W-1:0] addr_q;
  logic [2:0] io_sel_n_q;
  logic [1:0] st_sel_n_q;
  logic oe_n_q;
  logic [`EMB_DATA_W-1:0] dout_q;
  logic drive_q;
  logic [`EMB_DATA_W-1:0] rdata_q;
  logic done_q;
  // sdram command: activate on row, read/write on column, else nop
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sd_q <= '1;
    else if (going_row)
      sd_q <= '{bank_select_n: ~(2'h1 << req_v.bank[0]), row_strobe_n: 1'b0,
               col_strobe_n: 1'b1, write_n: 1'b1};
    else if (going_col)
      sd_q <= '{bank_select_n: sd_q.bank_select_n, row_strobe_n: 1'b1,
               col_strobe_n: 1'b0, write_n: !req_q.write};
    else
      sd_q <= '1;
  end
  // address pins: row, then column, or the static byte address
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      addr_q <= '0;
    else if (going_row)
      addr_q <= sd_row_pins;
    else if (going_col)
      addr_q <= sd_col_pins;
    else if (going_st)
      addr_q <= st_addr;
  end
  // static and i/o selects and shared oe held for the whole access
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      io_sel_n_q <= '1;
      st_sel_n_q <= '1;
      oe_n_q <= 1'b1;
    end
    else
    begin
      io_sel_n_q <= (going_st && is_io) ? ~(3'h1 << req_v.bank) : 3'h7;
      st_sel_n_q <= (going_st && is_st) ? ~(2'h1 << phys_bank) : 2'h3;
      oe_n_q <= !(going_st && !req_v.write);
    end
  end
  // write data driven on all four lanes for a static access, or from the sdram column cycle on; the data pattern follows the width
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dout_q <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      dout_q <= narrow_wdata;
      drive_q <= req_v.write && (going_st || (state_d == EMB_SD_COL));
    end
  end
  wire load_lanes = (state_q == EMB_IDLE) && (going_st || going_row);
  wire clear_lanes = (state_d == EMB_DONE);
  // one lane control per byte; mask bit n and write enable n face lane n
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_lane
    emb_lane_ctl u_lane (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .load_i(load_lanes),
      .clear_i(clear_lanes),
      .sdram_i(is_sd),
      .write_i(req_v.write),
      .en_i(lane_en[g]),
      .mask_o(sdram_byte_mask_o[g]),
      .wr_n_o(static_byte_write_n_o[g])
    );
  end
  // read capture at the end of an access, lane 0 up for narrow buses
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_d == EMB_DONE);
      if ((state_d == EMB_DONE) && !req_q.write)
        rdata_q <= (in_st && eff_width == `EMB_WIDTH_BYTE) ? {24'h0, data_i[7:0]}
          : (in_st && eff_width == `EMB_WIDTH_HALF) ? {16'h0, data_i[15:0]}
          : data_i;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sys_clock_out_o = clock_i;
  assign addr_o = addr_q;
  assign data_o = dout_q;
  assign data_oe_n_o = {4{!drive_q}};
  assign sdram_bank_select_n_o = sd_q.bank_select_n;
  assign sdram_row_strobe_n_o = sd_q.row_strobe_n;
  assign sdram_col_strobe_n_o = sd_q.col_strobe_n;
  assign sdram_write_n_o = sd_q.write_n;
  assign io_bank_select_n_o = io_sel_n_q;
  assign static_bank_select_n_o = st_sel_n_q;
  assign static_output_enable_n_o = oe_n_q;
  assign rdata_o = rdata_q;
  assign done_o = done_q;
endmodule // emb_mem_bus
`default_nettype wire

// [emb_mem_bus_chk.sv]
// emb_mem_bus_chk.sv: pin protocol checks for the memory bus sequencer.
// assumes: bound to emb_mem_bus, sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_bus_chk (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic done_o, // access done
  input wire logic ext_wait_n_i, // wait pin
  input wire logic [1:0] sdram_bank_select_n_o, // sdram selects
  input wire logic sdram_row_strobe_n_o, // row strobe
  input wire logic sdram_col_strobe_n_o, // column strobe
  input wire logic [3:0] sdram_byte_mask_o, // byte masks
  input wire logic [2:0] io_bank_select_n_o, // i/o selects
  input wire logic [1:0] static_bank_select_n_o, // static selects
  input wire logic static_output_enable_n_o // output enable
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // sdram and static pin relations
  // ----------------------------------------
  // any static or i/o access in progress
  wire st_sel = !(&static_bank_select_n_o) || !(&io_bank_select_n_o);
  sequence row_s;
    !sdram_row_strobe_n_o;
  endsequence
  sequence col_s;
    sdram_row_strobe_n_o && !sdram_col_strobe_n_o;
  endsequence
  sd_sel_one_a: assert property ($countones(~sdram_bank_select_n_o) <= 1)
    else $error("two sdram selects low");
  io_sel_one_a: assert property ($countones(~io_bank_select_n_o) <= 1)
    else $error("two io selects low");
  st_sel_one_a: assert property ($countones(~static_bank_select_n_o) <= 1)
    else $error("two static selects low");
  row_col_a: assert property (row_s |=> col_s)
    else $error("column strobe does not follow row strobe");
  sd_done_a: assert property (row_s |-> ##4 done_o)
    else $error("sdram access not done four cycles after row");
  mask_idle_a: assert property (st_sel |-> sdram_byte_mask_o == 4'hF)
    else $error("sdram mask active in static access");
  sd_apart_a: assert property (st_sel |-> sdram_row_strobe_n_o && &sdram_bank_select_n_o)
    else $error("sdram strobe during static access");
  oe_static_a: assert property (!static_output_enable_n_o |-> st_sel)
    else $error("output enable without select");
  wait_hold_a: assert property (st_sel && !ext_wait_n_i |=> !done_o)
    else $error("access ended while wait held");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
endmodule // emb_mem_bus_chk
bind emb_mem_bus emb_mem_bus_chk u_emb_mem_bus_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .done_o(done_o), .ext_wait_n_i(ext_wait_n_i), .sdram_bank_select_n_o(sdram_bank_select_n_o),
  .sdram_row_strobe_n_o(sdram_row_strobe_n_o), .sdram_col_strobe_n_o(sdram_col_strobe_n_o),
  .sdram_byte_mask_o(sdram_byte_mask_o), .io_bank_select_n_o(io_bank_select_n_o),
  .static_bank_select_n_o(static_bank_select_n_o),
  .static_output_enable_n_o(static_output_enable_n_o));
`default_nettype wire

// [emb_mem_dev.sv]
// emb_mem_dev.sv: board model of memories, wait source and strap resistor.
// assumes: static data is {10'h2B5, address}, sdram read data a constant.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_dev (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [3:0] wait_len_i, // wait cycles per access
  input wire logic wdog_strap_i, // strap resistor level
  input wire logic [21:0] addr_i, // address pins
  input wire logic [31:0] data_i, // device data drive
  input wire logic [3:0] data_oe_n_i, // device lane enables
  input wire logic sd_col_n_i, // sdram column strobe
  input wire logic [4:0] sel_n_i, // i/o and static selects
  input wire logic oe_n_i, // oe pin drive
  input wire logic oe_en_n_i, // oe pin enable
  output logic [31:0] bus_o, // data pin level
  output logic wait_n_o, // wait pin
  output logic oe_pin_o // oe pin level
);
  // ----------------------------------------
  // far side drive
  // ----------------------------------------
  logic [3:0] cnt_q;
  logic [2:0] sd_q;
  logic tog_q;
  wire acc = !(&sel_n_i);
  // released lanes toggle so a stale value never looks valid
  wire [31:0] far = acc ? {10'h2B5, addr_i} : (sd_q != 3'h0) ? 32'hC3A5_5A3C :
    {32{tog_q}} ^ 32'h0F0F_0F0F;
  wire [31:0] m = {{8{data_oe_n_i[3]}}, {8{data_oe_n_i[2]}}, {8{data_oe_n_i[1]}},
    {8{data_oe_n_i[0]}}};
  assign bus_o = (far & m) | (data_i & ~m);
  assign wait_n_o = !(acc && cnt_q < wait_len_i);
  assign oe_pin_o = oe_en_n_i ? wdog_strap_i : oe_n_i;
  // access age and sdram read window after the column strobe
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 4'h0;
      sd_q <= 3'h0;
      tog_q <= 1'b0;
    end
    else
    begin
      cnt_q <= acc ? cnt_q + {3'h0, cnt_q != 4'hF} : 4'h0;
      sd_q <= !sd_col_n_i ? 3'h1 : (sd_q != 3'h0 && sd_q < 3'h5) ? sd_q + 3'h1 : 3'h0;
      tog_q <= !tog_q;
    end
  end
endmodule // emb_mem_dev
`default_nettype wire

// [tb_emb_mem_bus.sv]
// tb_emb_mem_bus.sv: directed tests of straps, static, i/o and sdram cycles.
// assumes: emb_mem_dev answers on the far side.
`timescale 1ns/1ps
`default_nettype none
module tb_emb_mem_bus;
  import emb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, swap = 1'b0, pol = 1'b0;
  logic [1:0] w1 = 2'h3, strap = 2'h3, bw, sdsel, stsel;
  logic [3:0] wlen = 4'h0, doe, mask;
  emb_req_s req = '0;
  logic done, wdog, bwbad, sclk, ras, cas, we, oe_n, oe_en, oe_pin, wait_n;
  logic [21:0] addr;
  logic [31:0] rdata, dout, din, rowa, cold, sta, std;
  logic [2:0] iosel;
  logic [4:0] sel_and;
  logic [1:0] sd_and;
  logic [3:0] mask_and;
  logic oe_seen, colwe;
  logic [3:0] bwn, bwn_and, doe_and;
  int mismatches = 0, check_count = 0, n, n0;
  initial forever #20 clk = ~clk;
  emb_mem_bus u_emb_mem_bus (.clock_i(clk), .arst_n_i(rst_n), .req_valid_i(vld), .req_i(req),
    .static_swap_i(swap), .static1_width_i(w1), .done_o(done), .rdata_o(rdata),
    .wdog_active_high_o(wdog), .boot_width_o(bw), .boot_width_bad_o(bwbad),
    .sys_clock_out_o(sclk), .addr_o(addr), .data_i(din), .data_o(dout), .data_oe_n_o(doe),
    .sdram_bank_select_n_o(sdsel), .sdram_row_strobe_n_o(ras), .sdram_col_strobe_n_o(cas),
    .sdram_write_n_o(we), .sdram_byte_mask_o(mask), .static_byte_write_n_o(bwn),
    .io_bank_select_n_o(iosel),
    .static_bank_select_n_o(stsel), .static_output_enable_n_i(oe_pin),
    .static_output_enable_n_o(oe_n), .static_output_enable_oe_n_o(oe_en),
    .boot_bank_width_strap_i(strap), .ext_wait_n_i(wait_n));
  emb_mem_dev u_emb_mem_dev (.clock_i(clk), .arst_n_i(rst_n), .wait_len_i(wlen),
    .wdog_strap_i(pol), .addr_i(addr), .data_i(dout), .data_oe_n_i(doe), .sd_col_n_i(cas),
    .sel_n_i({iosel, stsel}), .oe_n_i(oe_n), .oe_en_n_i(oe_en), .bus_o(din),
    .wait_n_o(wait_n), .oe_pin_o(oe_pin));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // straps must be stable across the whole reset, so they change with it
  task automatic do_reset(input logic p, input logic [1:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    pol <= p;
    strap <= s;
    repeat (2) @(posedge clk);
    #1 chk(oe_en, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({bwbad, wdog, oe_en, bw}, {s == 2'h0, p, 1'b0, s});
  endtask
  // one request held until done, pins gathered on every cycle
  task automatic access(input emb_tgt_e t, input logic [1:0] b, input logic wr,
    input logic [3:0] be, input logic [21:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{tgt: t, bank: b, write: wr, byte_en: be, addr: a, wdata: wd};
    vld <= 1'b1;
    {n, sel_and, sd_and, mask_and, oe_seen} = {32'h0, 5'h1F, 2'h3, 4'hF, 1'b0};
    {bwn_and, doe_and} = 8'hFF;
    do
    begin
      @(posedge clk);
      #1 n++;
      sel_and &= {iosel, stsel};
      sd_and &= sdsel;
      mask_and &= mask;
      bwn_and &= bwn;
      doe_and &= doe;
      oe_seen |= (oe_n === 1'b0);
      if (ras === 1'b0)
        rowa = addr;
      if (cas === 1'b0)
        {cold, colwe} = {dout, we};
      if ((&{iosel, stsel}) === 1'b0)
        {sta, std} = {10'h0, addr, dout};
    end while (done !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      mismatches++;
      give_verdict();
    end
    @(posedge clk);
    vld <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 4; i++)
      do_reset(i[0], i[1:0]);
    do_reset(1'b0, 2'h1);
    $display("test straps done");
    access(EMB_TGT_STATIC, 2'h0, 1'b0, 4'hF, 22'h00035C, 32'h0);
    chk(rdata, 32'h5C);
    chk({sel_and, oe_seen, sta}, {5'h1E, 1'b1, 32'h35C});
    chk({bwn_and, doe_and}, 8'hFF);
    w1 <= 2'h2;
    access(EMB_TGT_STATIC, 2'h1, 1'b0, 4'h3, 22'h123456, 32'h0);
    chk({rdata, sel_and}, {32'h3456, 5'h1D});
    swap <= 1'b1;
    access(EMB_TGT_STATIC, 2'h0, 1'b0, 4'hF, 22'h000100, 32'h0);
    chk(sel_and, 5'h1D);
    {swap, w1} <= 3'h3;
    access(EMB_TGT_STATIC, 2'h1, 1'b1, 4'hF, 22'h000200, 32'h89AB_CDEF);
    chk({oe_seen, mask_and, std}, {1'b0, 4'hF, 32'h89AB_CDEF});
    chk({bwn_and, doe_and}, 8'h00);
    access(EMB_TGT_STATIC, 2'h0, 1'b1, 4'hF, 22'h000301, 32'h0000_AB00);
    chk({bwn_and, std[7:0], sta}, {4'hE, 8'hAB, 32'h301});
    $display("test static done");
    for (int b = 0; b < 3; b++)
    begin
      access(EMB_TGT_IO, b[1:0], 1'b0, 4'hF, 22'h000010, 32'h0);
      chk(sel_and, {~(3'h1 << b), 2'h3});
    end
    n0 = n;
    wlen <= 4'h8;
    access(EMB_TGT_IO, 2'h0, 1'b0, 4'hF, 22'h000010, 32'h0);
    chk(n, n0 + 5);
    wlen <= 4'h0;
    $display("test io and wait done");
    for (int b = 0; b < 2; b++)
    begin
      access(EMB_TGT_SDRAM, b[1:0], 1'b1, 4'h5 << b, 22'h1ABCD4 ^ (b << 20), 32'h1234_5678);
      chk({sd_and, mask_and, colwe}, {~(2'h1 << b), ~(4'h5 << b), 1'b0});
      chk(cold & (32'h00FF_00FF << (8 * b)), 32'h1234_5678 & (32'h00FF_00FF << (8 * b)));
      chk({rowa[21:20], n[7:0]}, {2'h1 ^ b[1:0], 8'h5});
      chk({bwn_and, doe_and}, 8'hF0);
    end
    access(EMB_TGT_SDRAM, 2'h0, 1'b0, 4'hF, 22'h000040, 32'h0);
    chk({rdata, mask_and, colwe}, {32'hC3A5_5A3C, 4'h0, 1'b1});
    #1 chk(sclk, clk);
    #20 chk(sclk, clk);
    $display("test sdram done");
    give_verdict();
  end
endmodule // tb_emb_mem_bus
`default_nettype wire
